//--- adchw_front.sv
`timescale 1ns/1ps
`default_nettype none
module adchw_front (
    // clock and request
    input wire logic aclk,
    input wire logic fire,
    // converter side
    input wire logic [adchw_pkg::CH_W-1:0] adc_channel,
    input wire logic adc_busy,
    output logic hw_trigger,
    output logic [adchw_pkg::RES_W-1:0] adc_sample
);
    // ******************************
    // trigger source and analog front end
    // ******************************
    always_ff @(posedge aclk) begin
        hw_trigger <= fire;
    end
    // idle front end shows scrambled data
    assign adc_sample = adc_busy ? {6'h2C, adc_channel} : ~{6'h2C, adc_channel};
endmodule : adchw_front
`default_nettype wire

//--- adchw_pkg.sv
// How it works
// - enable bit set from stop moves the sequencer into trigger standby
// - select mode: trigger in standby converts the selected channel, sets running bit
// - select one-shot: finished conversion writes result pair, pulses conversion-end request
// - select one-shot: running bit clears itself after conversion ends
// - select mode: trigger during conversion aborts it and restarts
// - select mode: a channel select write with byte lane 0 strobed during conversion restarts on new input
// - select mode: writing running bit 1 during conversion restarts it
// - clearing running bit with enable bit kept set during conversion aborts it, back to trigger standby
// - triggers are ignored while the enable bit is zero
// - scan mode: trigger converts slots zero to three in order, sets running bit
// - scan mode: every channel conversion writes result pair and pulses request
// - scan sequential: after four channels conversion continues without a trigger
// - scan mode: trigger during conversion restarts the group from slot zero
// - scan mode: channel select write during conversion restarts new group slot zero
// - scan mode: writing running bit 1 during conversion restarts the conversion
package adchw_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_CHSEL = 8'h04;
    localparam logic [7:0] OFF_RESULT = 8'h08;
    localparam logic [7:0] OFF_RESULT_HI = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int MODE_ENABLE_BIT = 0;
    localparam int MODE_RUNNING_BIT = 1;
    localparam int MODE_SCAN_BIT = 2;
    localparam int IRQ_CONV_END_BIT = 0;
    localparam int RES_HI_SHIFT = 2;
    localparam logic [3:0] CHSEL_RESET = 4'h0;
    localparam logic IRQ_MASK_RESET = 1'b0;

    // ****************************************
    // widths and timing
    // ****************************************
    localparam int CH_W = 4;
    localparam int RES_W = 10;
    localparam int SLOT_W = 2;
    localparam logic [1:0] SLOT_LAST = 2'h3;
    localparam int CLK_PERIOD_NS = 100;
    localparam int CONV_TIME_NS = 2000;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic scan;
        logic running;
        logic enable;
    } adchw_mode_s;

    typedef enum logic [2:0] {
        ST_STOP = 3'b001,
        ST_STANDBY = 3'b010,
        ST_CONV = 3'b100
    } adchw_state_e;

endpackage : adchw_pkg

//--- adchw_seq.sv
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module adchw_seq #(
    parameter int CONV_CYCLES = adchw_pkg::CONV_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // trigger and converter front end
    input wire logic hw_trigger,
    input wire logic [adchw_pkg::RES_W-1:0] adc_sample,
    output logic [adchw_pkg::CH_W-1:0] adc_channel,
    output logic adc_busy,
    // interrupts
    output logic conv_end_irq,
    output logic irq
);

    // ****************************************
    // write channel capture
    // ****************************************
    logic aw_hold;
    logic w_hold;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    wire aw_hs = awvalid && awready;
    wire w_hs = wvalid && wready;
    wire b_hs = bvalid && bready;
    wire wr_fire = aw_hold && w_hold && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            awready <= 1'b1;
            wr_addr <= 8'h00;
        end else if (aw_hs) begin
            aw_hold <= 1'b1;
            awready <= 1'b0;
            wr_addr <= awaddr;
        end else if (b_hs) begin
            aw_hold <= 1'b0;
            awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold <= 1'b0;
            wready <= 1'b1;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
        end else if (w_hs) begin
            w_hold <= 1'b1;
            wready <= 1'b0;
            wr_data <= wdata;
            wr_strb <= wstrb;
        end else if (b_hs) begin
            w_hold <= 1'b0;
            wready <= 1'b1;
        end
    end

    // ****************************************
    // write decode
    // ****************************************
    wire wr_known = (wr_addr == adchw_pkg::OFF_MODE) || (wr_addr == adchw_pkg::OFF_CHSEL)
        || (wr_addr == adchw_pkg::OFF_RESULT) || (wr_addr == adchw_pkg::OFF_RESULT_HI)
        || (wr_addr == adchw_pkg::OFF_IRQ_STAT) || (wr_addr == adchw_pkg::OFF_IRQ_MASK)
        || (wr_addr == adchw_pkg::OFF_STATUS);
    wire wr_lo = wr_fire && wr_strb[0];
    wire wr_mode = wr_lo && (wr_addr == adchw_pkg::OFF_MODE);
    wire wr_chsel = wr_lo && (wr_addr == adchw_pkg::OFF_CHSEL);
    wire wr_stat = wr_lo && (wr_addr == adchw_pkg::OFF_IRQ_STAT);
    wire wr_mask = wr_lo && (wr_addr == adchw_pkg::OFF_IRQ_MASK);
    wire wd_enable = wr_data[adchw_pkg::MODE_ENABLE_BIT];
    wire wd_running = wr_data[adchw_pkg::MODE_RUNNING_BIT];
    wire wd_scan = wr_data[adchw_pkg::MODE_SCAN_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= adchw_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= wr_known ? adchw_pkg::RESP_OKAY : adchw_pkg::RESP_SLVERR;
        end else if (b_hs) begin
            bvalid <= 1'b0;
        end
    end

    // ****************************************
    // sequencer state
    // ****************************************
    adchw_pkg::adchw_state_e state;
    adchw_pkg::adchw_state_e next_state;
    adchw_pkg::adchw_mode_s mode;
    logic [adchw_pkg::CH_W-1:0] chsel;
    logic [adchw_pkg::SLOT_W-1:0] slot;
    logic [adchw_pkg::SLOT_W-1:0] next_slot;
    logic [adchw_pkg::RES_W-1:0] result;
    logic [adchw_pkg::CH_W-1:0] result_ch;
    logic stat;
    logic mask;
    logic start_conv;
    logic abort_conv;
    logic accept_done;
    logic timer_busy;
    logic timer_done;

    wire in_conv = (state == adchw_pkg::ST_CONV);
    wire next_enable = wr_mode ? wd_enable : mode.enable;
    wire next_scan = wr_mode ? wd_scan : mode.scan;
    wire [adchw_pkg::CH_W-1:0] next_chsel = wr_chsel ? wr_data[adchw_pkg::CH_W-1:0] : chsel;
    wire trig = hw_trigger && mode.enable;
    wire sw_restart = wr_mode && wd_running && in_conv;
    wire sw_stop = wr_mode && !wd_running && in_conv;
    wire restart = trig || wr_chsel || sw_restart;

    always_comb begin
        next_state = state;
        next_slot = slot;
        start_conv = 1'b0;
        abort_conv = 1'b0;
        accept_done = 1'b0;
        case (state)
            adchw_pkg::ST_STOP: begin
                if (mode.enable) begin
                    next_state = adchw_pkg::ST_STANDBY;
                end
            end
            adchw_pkg::ST_STANDBY: begin
                if (!mode.enable) begin
                    next_state = adchw_pkg::ST_STOP;
                end else if (trig) begin
                    next_state = adchw_pkg::ST_CONV;
                    next_slot = '0;
                    start_conv = 1'b1;
                end
            end
            adchw_pkg::ST_CONV: begin
                if (!next_enable) begin
                    next_state = adchw_pkg::ST_STOP;
                    abort_conv = 1'b1;
                end else if (sw_stop) begin
                    next_state = adchw_pkg::ST_STANDBY;
                    abort_conv = 1'b1;
                end else if (restart) begin
                    next_slot = '0;
                    start_conv = 1'b1;
                end else if (timer_done) begin
                    accept_done = 1'b1;
                    if (!mode.scan) begin
                        next_state = adchw_pkg::ST_STANDBY;
                    end else begin
                        next_slot = (slot == adchw_pkg::SLOT_LAST) ? '0 : slot + 2'h1;
                        start_conv = 1'b1;
                    end
                end
            end
            default: begin
                next_state = adchw_pkg::ST_STOP;
                abort_conv = 1'b1;
            end
        endcase
    end

    // scan slots follow the select value upward, wrapping in the channel field
    wire [adchw_pkg::CH_W-1:0] next_channel = next_scan
        ? next_chsel + adchw_pkg::CH_W'(next_slot) : next_chsel;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= adchw_pkg::ST_STOP;
            slot <= '0;
            adc_channel <= adchw_pkg::CHSEL_RESET;
        end else begin
            state <= next_state;
            slot <= next_slot;
            adc_channel <= next_channel;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode <= '0;
            chsel <= adchw_pkg::CHSEL_RESET;
        end else begin
            mode.enable <= next_enable;
            mode.scan <= next_scan;
            mode.running <= (next_state == adchw_pkg::ST_CONV);
            chsel <= next_chsel;
        end
    end

    // ****************************************
    // conversion timing
    // ****************************************
    adchw_timer #(
        .CYCLES(CONV_CYCLES)
    ) u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(start_conv),
        .abort(abort_conv),
        .busy(timer_busy),
        .done(timer_done)
    );

    // ****************************************
    // results and interrupts
    // ****************************************
    wire next_stat = (stat && !(wr_stat && wr_data[adchw_pkg::IRQ_CONV_END_BIT])) || accept_done;
    wire next_mask = wr_mask ? wr_data[adchw_pkg::IRQ_CONV_END_BIT] : mask;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result <= '0;
            result_ch <= '0;
            conv_end_irq <= 1'b0;
            stat <= 1'b0;
            mask <= adchw_pkg::IRQ_MASK_RESET;
            irq <= 1'b0;
            adc_busy <= 1'b0;
        end else begin
            if (accept_done) begin
                result <= adc_sample;
                result_ch <= adc_channel;
            end
            conv_end_irq <= accept_done;
            stat <= next_stat;
            mask <= next_mask;
            irq <= next_stat && next_mask;
            adc_busy <= (timer_busy || start_conv) && !abort_conv;
        end
    end

    // ****************************************
    // read channel
    // ****************************************
    wire ar_hs = arvalid && arready;
    wire r_hs = rvalid && rready;
    logic [31:0] rd_mux;
    logic rd_known;

    always_comb begin
        rd_mux = 32'h00000000;
        rd_known = 1'b1;
        case (araddr)
            adchw_pkg::OFF_MODE: rd_mux = 32'(mode);
            adchw_pkg::OFF_CHSEL: rd_mux = 32'(chsel);
            adchw_pkg::OFF_RESULT: rd_mux = 32'(result);
            adchw_pkg::OFF_RESULT_HI: rd_mux = 32'(result >> adchw_pkg::RES_HI_SHIFT);
            adchw_pkg::OFF_IRQ_STAT: rd_mux = 32'(stat);
            adchw_pkg::OFF_IRQ_MASK: rd_mux = 32'(mask);
            adchw_pkg::OFF_STATUS: rd_mux = {22'h000000, result_ch, 1'b0, slot, state};
            default: rd_known = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= adchw_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= rd_known ? adchw_pkg::RESP_OKAY : adchw_pkg::RESP_SLVERR;
        end else if (r_hs) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
        end
    end

endmodule : adchw_seq
`default_nettype wire

//--- adchw_seq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module adchw_monitor #(
    parameter int CONV_CYCLES = adchw_pkg::CONV_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic wvalid,
    input wire logic wready,
    input wire logic rvalid,
    input wire logic rready,
    // converter side
    input wire logic hw_trigger,
    input wire logic [adchw_pkg::CH_W-1:0] adc_channel,
    input wire logic adc_busy,
    input wire logic conv_end_irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ******************************
    // cycles since the conversion began
    // ******************************
    logic [7:0] since;
    logic dirty;
    always_ff @(posedge aclk) begin
        if (!aresetn || hw_trigger) begin
            since <= 8'h00;
        end else if (conv_end_irq) begin
            since <= 8'h01;
        end else if (since != 8'hFF) begin
            since <= since + 8'h01;
        end
    end
    // bus writes may restart, so timing is judged only after a clean trigger
    always_ff @(posedge aclk) begin
        if (!aresetn || hw_trigger) begin
            dirty <= 1'b0;
        end else if (wvalid && wready) begin
            dirty <= 1'b1;
        end
    end
    chk_conv_time: assert property (
        conv_end_irq && !dirty |-> since == 8'(CONV_CYCLES + 1))
        else $error("conversion end at wrong cycle");
    chk_pulse_single: assert property (conv_end_irq |=> !conv_end_irq)
        else $error("conversion end pulse too long");
    chk_trig_abort: assert property (
        hw_trigger && adc_busy |=> adc_busy && !conv_end_irq)
        else $error("trigger did not restart conversion");
    chk_busy_cause: assert property ($rose(adc_busy) |-> $past(hw_trigger))
        else $error("conversion began without trigger");
    chk_select_stop: assert property (
        conv_end_irq && !adc_busy && !hw_trigger |=> !adc_busy)
        else $error("one-shot did not stop");
    chk_scan_step: assert property (
        conv_end_irq && adc_busy |-> adc_channel == $past(adc_channel) + 4'h1
            || adc_channel == $past(adc_channel) - 4'h3)
        else $error("scan channel order broken");
    chk_no_stray: assert property (!adc_busy && !$past(adc_busy) |-> !conv_end_irq)
        else $error("conversion end without conversion");
    chk_write_block: assert property (wvalid && wready |=> !wready)
        else $error("write data accepted while busy");
    chk_read_once: assert property (rvalid && rready |=> !rvalid)
        else $error("read answer repeated");
    cover property (conv_end_irq && adc_busy);
    cover property (hw_trigger && adc_busy);
    cover property ($fell(adc_busy) && !conv_end_irq);
endmodule : adchw_monitor
bind adchw_seq adchw_monitor #(.CONV_CYCLES(CONV_CYCLES)) u_adchw_monitor (
    .aclk, .aresetn, .wvalid, .wready, .rvalid, .rready,
    .hw_trigger, .adc_channel, .adc_busy, .conv_end_irq
);
`default_nettype wire

//--- adchw_seq_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adchw_seq_tb;
    localparam int CV = 6;
    logic aclk, aresetn, fire, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, hw_trigger, adc_busy, conv_end_irq, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, adc_channel;
    logic [1:0] bresp, rresp;
    logic [9:0] adc_sample;
    int n_errors, total_checks;
    adchw_seq #(.CONV_CYCLES(CV)) u_adchw_seq (.aclk, .aresetn, .awvalid, .awready, .awaddr,
        .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
        .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .hw_trigger,
        .adc_sample, .adc_channel, .adc_busy, .conv_end_irq, .irq);
    adchw_front u_adchw_front (.aclk, .fire, .adc_channel, .adc_busy, .hw_trigger, .adc_sample);
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // ******************************
    // checks, bus cycles, stimulus
    // ******************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_bit(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk_bit
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    task automatic hang;
        n_errors++;
        test_done();
    endtask : hang
    function automatic logic [31:0] res(input logic [3:0] ch);
        return {22'h0, 6'h2C, ch};
    endfunction : res
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic got;
        got = 1'b0;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        for (int i = 0; i < 40 && !got; i++) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                bready <= 1'b0;
                got = 1'b1;
                chk({30'h0, bresp}, {30'h0, adchw_pkg::RESP_OKAY});
            end
        end
        if (!got) hang();
    endtask : wr
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic got;
        got = 1'b0;
        d = 32'h0;
        r = 2'h0;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        for (int i = 0; i < 40 && !got; i++) begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                rready <= 1'b0;
                d = rdata;
                r = rresp;
                got = 1'b1;
            end
        end
        if (!got) hang();
    endtask : rd_reg
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd_reg(a, d, r);
        chk(d & m, e);
        chk({30'h0, r}, {30'h0, adchw_pkg::RESP_OKAY});
    endtask : rchk
    task automatic trig;
        @(posedge aclk);
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
    endtask : trig
    task automatic wait_end(input int lat);
        int i;
        for (i = 1; i <= 60; i++) begin
            @(posedge aclk);
            if (conv_end_irq === 1'b1) break;
        end
        if (i > 60) hang();
        if (lat > 0) chk(32'(i), 32'(lat));
    endtask : wait_end
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        {aresetn, fire, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hF;
        n_errors = 0;
        total_checks = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(adchw_pkg::OFF_MODE, 32'h7, 32'h0);
        rchk(adchw_pkg::OFF_CHSEL, 32'hF, 32'h0);
        rchk(adchw_pkg::OFF_IRQ_MASK, 32'h1, 32'h0);
        rd_reg(8'h1C, d, r);
        chk({30'h0, r}, {30'h0, adchw_pkg::RESP_SLVERR});
        trig();
        repeat (CV + 4) @(posedge aclk);
        chk_bit(adc_busy, 1'b0);
        rchk(adchw_pkg::OFF_STATUS, 32'h7, 32'h1);
        wr(adchw_pkg::OFF_IRQ_MASK, 32'h1);
        wr(adchw_pkg::OFF_CHSEL, 32'h5);
        wr(adchw_pkg::OFF_MODE, 32'h1);
        rchk(adchw_pkg::OFF_STATUS, 32'h7, 32'h2);
        trig();
        rchk(adchw_pkg::OFF_MODE, 32'h7, 32'h3);
        wait_end(0);
        chk_bit(irq, 1'b1);
        rchk(adchw_pkg::OFF_RESULT, 32'hFFFFFFFF, res(4'h5));
        rchk(adchw_pkg::OFF_RESULT_HI, 32'hFFFFFFFF, res(4'h5) >> 2);
        rchk(adchw_pkg::OFF_MODE, 32'h7, 32'h1);
        rchk(adchw_pkg::OFF_STATUS, 32'h7, 32'h2);
        trig();
        repeat (3) @(posedge aclk);
        trig();
        wait_end(CV + 3);
        trig();
        wr(adchw_pkg::OFF_CHSEL, 32'h9);
        wait_end(0);
        rchk(adchw_pkg::OFF_RESULT, 32'h3FF, res(4'h9));
        trig();
        repeat (2) @(posedge aclk);
        wr(adchw_pkg::OFF_MODE, 32'h3);
        wait_end(CV + 1);
        trig();
        wr(adchw_pkg::OFF_MODE, 32'h1);
        repeat (CV + 4) @(posedge aclk);
        chk_bit(adc_busy, 1'b0);
        rchk(adchw_pkg::OFF_STATUS, 32'h7, 32'h2);
        wr(adchw_pkg::OFF_CHSEL, 32'hE);
        wr(adchw_pkg::OFF_MODE, 32'h5);
        trig();
        for (int n = 0; n < 6; n++) begin
            wait_end(n == 0 ? CV + 3 : 0);
            rchk(adchw_pkg::OFF_RESULT, 32'h3FF, res(4'hE + 4'(n % 4)));
        end
        trig();
        wait_end(CV + 3);
        rchk(adchw_pkg::OFF_RESULT, 32'h3FF, res(4'hE));
        wr(adchw_pkg::OFF_CHSEL, 32'h2);
        wait_end(0);
        rchk(adchw_pkg::OFF_RESULT, 32'h3FF, res(4'h2));
        wait_end(0);
        rchk(adchw_pkg::OFF_RESULT, 32'h3FF, res(4'h3));
        wr(adchw_pkg::OFF_MODE, 32'h7);
        wait_end(CV + 1);
        rchk(adchw_pkg::OFF_RESULT, 32'h3FF, res(4'h2));
        wr(adchw_pkg::OFF_MODE, 32'h5);
        repeat (CV + 4) @(posedge aclk);
        chk_bit(adc_busy, 1'b0);
        wr(adchw_pkg::OFF_IRQ_MASK, 32'h0);
        @(posedge aclk);
        chk_bit(irq, 1'b0);
        wr(adchw_pkg::OFF_IRQ_MASK, 32'h1);
        @(posedge aclk);
        chk_bit(irq, 1'b1);
        wr(adchw_pkg::OFF_IRQ_STAT, 32'h1);
        @(posedge aclk);
        chk_bit(irq, 1'b0);
        test_done();
    end
endmodule : adchw_seq_tb
`default_nettype wire

//--- adchw_timer.sv
`timescale 1ns/1ps
`default_nettype none
module adchw_timer #(
    parameter int CYCLES = adchw_pkg::CONV_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic start,
    input wire logic abort,
    // status
    output logic busy,
    output logic done
);

    logic [15:0] cnt;
    wire last = (cnt == 16'(CYCLES - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= 16'h0000;
            busy <= 1'b0;
            done <= 1'b0;
        end else if (abort) begin
            cnt <= 16'h0000;
            busy <= 1'b0;
            done <= 1'b0;
        end else if (start) begin
            cnt <= 16'h0000;
            busy <= 1'b1;
            done <= 1'b0;
        end else begin
            cnt <= (busy && !last) ? cnt + 16'h0001 : 16'h0000;
            busy <= busy && !last;
            done <= busy && last;
        end
    end

endmodule : adchw_timer
`default_nettype wire
